// >>> verilog/ddr_pwr_regs.svh
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: 32-bit AXI4-Lite words, one register per aligned word
// Notes: definitions only, shared by the burst order block, the top module and the bench
`ifndef DDR_PWR_REGS_SVH
`define DDR_PWR_REGS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MODE 8'h08
`define OFS_EXT 8'h0c
`define OFS_REFRESH 8'h10

// Control register fields and reset value of the decode enable
`define CTRL_DEC_BIT 0
`define CTRL_CLR_BIT 1
`define CTRL_DEC_RESET 1'b1

// Address pin count and base mode register fields
`define ADDR_W 13
`define MODE_RESET 13'h0000
`define MR_BL_LSB 0
`define MR_BL_MSB 2
`define MR_ORDER_BIT 3
`define MR_LAT_LSB 4
`define MR_LAT_MSB 6

// Burst length codes on the low mode field
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define BL_CODE_16 3'h4

// Extended mode register fields; undefined bits are masked to zero
`define EM_PARTIAL_REFRESH_RANGE_LSB 0
`define EM_PARTIAL_REFRESH_RANGE_MSB 2
`define EM_DS_LSB 5
`define EM_DS_MSB 6
`define EM_AUTO_TEMP_REFRESH_EN_BIT 9
`define EM_MASK 13'h0267

// Timing: mode set delay in link clocks, refresh interval in ns
`define MRD_TCK 2
`define REFI_NS 7800
`define ACLK_MHZ 40
`define REFI_CYC ((`REFI_NS * `ACLK_MHZ) / 1000)

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> verilog/ddr_pwr_pkg.sv
// Purpose: shared types of the power state and mode block
// Assumes: nothing beyond the register header
// Notes: states are one-hot
package ddr_pwr_pkg;

    // Power and command state of the device
    typedef enum logic [3:0] {
        ST_NORMAL = 4'h1,
        ST_PWRDN = 4'h2,
        ST_SREF = 4'h4,
        ST_MRD = 4'h8
    } pstate_t;

    // Decoded command strobe coding
    typedef enum logic [2:0] {
        C_DESELECT_CMD = 3'h0,
        C_NOP = 3'h1,
        C_STOP = 3'h2,
        C_RW = 3'h3,
        C_ACT = 3'h4,
        C_PRE = 3'h5,
        C_REF = 3'h6,
        C_MRS = 3'h7
    } cmd_t;

endpackage : ddr_pwr_pkg

// >>> verilog/pin_sync.sv
// Purpose: two-flop synchroniser for a group of pins
// Assumes: pins change slowly against aclk
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // Both stages held in one record
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_st_t;

    sync_st_t r_q;
    sync_st_t r_d;

    // Shift the pins through the two stages
    always_comb begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    // Frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_q <= '0;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;

endmodule : pin_sync

// >>> verilog/burst_order.sv
// Purpose: column low bits of one burst beat
// Assumes: beat index below the burst length
// Notes: a reserved length code gives a single beat
`timescale 1ns/1ps
`include "ddr_pwr_regs.svh"
module burst_order (
    input wire logic [3:0] start,
    input wire logic [3:0] beat,
    input wire logic [2:0] bl_code,
    input wire logic interleave,
    output logic [4:0] len,
    output logic [3:0] col
);

    logic [3:0] mask; // Bits that wrap inside the burst

    // Length mask, then wrap or exclusive-or inside it
    always_comb begin
        case (bl_code)
            `BL_CODE_2: mask = 4'h1;
            `BL_CODE_4: mask = 4'h3;
            `BL_CODE_8: mask = 4'h7;
            `BL_CODE_16: mask = 4'hf;
            default: mask = 4'h0;
        endcase
        len = {1'b0, mask} + 5'h01;
        if (interleave) begin
            col = (start & ~mask) | ((start ^ beat) & mask);
        end else begin
            col = (start & ~mask) | ((start + beat) & mask);
        end
    end

endmodule : burst_order

// >>> verilog/ddr_pwr_ctrl.sv
// Purpose: power states, mode registers and command checks of the memory
// Assumes: controller pins sampled on aclk, link clock far slower
// Notes: registers over AXI4-Lite; illegal commands set a sticky flag
// Operation
// - Bank-illegal command may suit another bank
// - Precharge of idle bank does nothing
// - Power down exit needs deselect or no-op
// - Clock enable rise wakes without clock edge
// - Clock enable fall with no-op: power down
// - Clock enable fall with refresh: self refresh
// - Clock enable high twice: normal decoding
// - Mode register undefined until written
// - All strobes and both bank bits low: base write
// - Mode write takes two clocks
// - Burst length, order, latency field places
// - Sequential order wraps start plus beat
// - Interleaved order is start xor beat
// - Bank bit1 high selects extended write
// - Extended fields: strength, temperature, partial range
// - Self refresh covers only selected portion
// - Temperature mode adjusts self refresh rate
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ddr_pwr_regs.svh"
module ddr_pwr_ctrl #(
    parameter int REFI_CYC = `REFI_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic mem_clk,
    input wire logic mem_cke,
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [1:0] mem_ba,
    input wire logic [`ADDR_W-1:0] mem_addr,
    input wire logic temp_hot,
    output logic [3:0] burst_col,
    output logic burst_valid,
    output logic [`ADDR_W-1:0] refresh_row,
    output logic refresh_stb,
    output logic [1:0] drive_strength
);

    localparam int AW = `ADDR_W;
    localparam int PW = 9 + AW;
    localparam int CW = $clog2(2 * REFI_CYC + 1);

    // Whole state of the block
    typedef struct packed {
        ddr_pwr_pkg::pstate_t pst;
        logic [1:0] mrd_cnt; // Link clocks left in a mode write
        logic clk_prev; // Link clock level seen last cycle
        logic cke_prev; // Clock enable at the last link edge
        logic [3:0] bank_act; // One bit per open bank
        logic [AW-1:0] mode; // Base mode register
        logic [AW-1:0] ext; // Extended mode register
        logic mode_ok; // Base register loaded
        logic ext_ok; // Extended register loaded
        logic illegal; // Sticky illegal command flag
        logic dec_en; // Software decode enable
        logic [3:0] start; // Burst start column bits
        logic [3:0] beat; // Burst beat index
        logic [4:0] left; // Beats still to issue
        logic [3:0] col; // Column of the current beat
        logic col_vld; // Beat valid
        logic [CW-1:0] ref_cnt; // Self refresh interval timer
        logic [AW-1:0] row; // Next row to refresh
        logic ref_stb; // One refresh done
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } top_st_t;

    top_st_t r_q;
    top_st_t r_d;

    // Synchronised pins
    logic [PW-1:0] pins_s;
    logic hot_s;
    logic clk_s;
    logic cke_s;
    logic [3:0] cmd_s;
    logic [1:0] ba_s;
    logic [AW-1:0] a_s;

    // Events of this cycle, also watched by the checks
    ddr_pwr_pkg::cmd_t cmd;
    logic edge_w;
    logic idle_all;
    logic bad;
    logic sref_go;
    logic pd_go;
    logic base_wr;
    logic ext_wr;
    logic rw_go;
    logic wr_go;
    logic rd_go;
    logic clr;
    logic [AW-1:0] partial_refresh_range_mask;
    logic [CW-1:0] interval;
    logic [4:0] bl_len;
    logic [3:0] col_w;

    // Strobe coding to command; used at link edges and at wake-up
    function automatic ddr_pwr_pkg::cmd_t decode(input logic [3:0] c);
        case (c)
            4'h7: decode = ddr_pwr_pkg::C_NOP;
            4'h6: decode = ddr_pwr_pkg::C_STOP;
            4'h5, 4'h4: decode = ddr_pwr_pkg::C_RW;
            4'h3: decode = ddr_pwr_pkg::C_ACT;
            4'h2: decode = ddr_pwr_pkg::C_PRE;
            4'h1: decode = ddr_pwr_pkg::C_REF;
            4'h0: decode = ddr_pwr_pkg::C_MRS;
            default: decode = ddr_pwr_pkg::C_DESELECT_CMD;
        endcase
    endfunction : decode

    // Mapped register check; shared by the read and write paths
    function automatic logic known(input logic [7:0] a);
        known = (a == `OFS_CTRL) || (a == `OFS_STATUS) || (a == `OFS_MODE) ||
            (a == `OFS_EXT) || (a == `OFS_REFRESH);
    endfunction : known

    // Every pin from the controller crosses two flops first
    pin_sync #(.W(PW)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .d({temp_hot, mem_clk, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n,
            mem_we_n, mem_ba, mem_addr}),
        .q(pins_s)
    );
    assign {hot_s, clk_s, cke_s, cmd_s, ba_s, a_s} = pins_s;

    // Burst column generator driven by the base mode fields
    burst_order u_burst (
        .start(r_q.start),
        .beat(r_q.beat),
        .bl_code(r_q.mode[`MR_BL_MSB:`MR_BL_LSB]),
        .interleave(r_q.mode[`MR_ORDER_BIT]),
        .len(bl_len),
        .col(col_w)
    );

    // Refreshed portion shrinks by powers of two
    always_comb begin
        case (r_q.ext[`EM_PARTIAL_REFRESH_RANGE_MSB:`EM_PARTIAL_REFRESH_RANGE_LSB])
            3'h1: partial_refresh_range_mask = {1'b0, {(AW-1){1'b1}}};
            3'h2: partial_refresh_range_mask = {2'b00, {(AW-2){1'b1}}};
            3'h5: partial_refresh_range_mask = {3'b000, {(AW-3){1'b1}}};
            3'h6: partial_refresh_range_mask = {4'h0, {(AW-4){1'b1}}};
            default: partial_refresh_range_mask = {AW{1'b1}};
        endcase
        // A cool die keeps data longer, so the rate halves
        if (r_q.ext[`EM_AUTO_TEMP_REFRESH_EN_BIT] && !hot_s) begin
            interval = CW'(2 * REFI_CYC - 1);
        end else begin
            interval = CW'(REFI_CYC - 1);
        end
    end

    // Next state of the whole block
    always_comb begin
        r_d = r_q;
        r_d.ref_stb = 1'b0;
        r_d.clk_prev = clk_s;
        cmd = decode(cmd_s);
        edge_w = clk_s & ~r_q.clk_prev;
        idle_all = (r_q.bank_act == 4'h0);
        bad = 1'b0;
        sref_go = 1'b0;
        pd_go = 1'b0;
        base_wr = 1'b0;
        ext_wr = 1'b0;
        rw_go = 1'b0;
        clr = 1'b0;
        case (r_q.pst)
            // Command decoding at each link clock edge
            ddr_pwr_pkg::ST_NORMAL: begin
                if (edge_w && r_q.dec_en) begin
                    r_d.cke_prev = cke_s;
                    if (r_q.cke_prev && !cke_s) begin
                        if (!idle_all) begin
                            bad = 1'b1;
                        end else if (cmd == ddr_pwr_pkg::C_REF) begin
                            sref_go = 1'b1;
                        end else if (cmd == ddr_pwr_pkg::C_DESELECT_CMD ||
                            cmd == ddr_pwr_pkg::C_NOP) begin
                            pd_go = 1'b1;
                        end else begin
                            bad = 1'b1;
                        end
                    end else if (r_q.cke_prev) begin
                        case (cmd)
                            ddr_pwr_pkg::C_ACT: begin
                                // Only the addressed bank is judged
                                if (r_q.bank_act[ba_s]) begin
                                    bad = 1'b1;
                                end else begin
                                    r_d.bank_act[ba_s] = 1'b1;
                                end
                            end
                            ddr_pwr_pkg::C_PRE: begin
                                // Closing a closed bank is harmless
                                if (a_s[10]) begin
                                    r_d.bank_act = 4'h0;
                                end else begin
                                    r_d.bank_act[ba_s] = 1'b0;
                                end
                            end
                            ddr_pwr_pkg::C_REF: begin
                                bad = !idle_all;
                            end
                            ddr_pwr_pkg::C_MRS: begin
                                if (!idle_all) begin
                                    bad = 1'b1;
                                end else if (ba_s[1]) begin
                                    ext_wr = 1'b1;
                                end else if (!ba_s[0]) begin
                                    base_wr = 1'b1;
                                end
                            end
                            ddr_pwr_pkg::C_RW: begin
                                // Undefined until the mode is loaded
                                if (!r_q.bank_act[ba_s] || !r_q.mode_ok) begin
                                    bad = 1'b1;
                                end else begin
                                    rw_go = 1'b1;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            // Mode write busy: only deselect or no-op may come
            ddr_pwr_pkg::ST_MRD: begin
                if (edge_w) begin
                    r_d.cke_prev = cke_s;
                    if (!cke_s || (cmd != ddr_pwr_pkg::C_DESELECT_CMD &&
                        cmd != ddr_pwr_pkg::C_NOP)) begin
                        bad = 1'b1;
                    end
                    if (r_q.mrd_cnt <= 2'h1) begin
                        r_d.pst = ddr_pwr_pkg::ST_NORMAL;
                    end else begin
                        r_d.mrd_cnt = r_q.mrd_cnt - 2'h1;
                    end
                end
            end
            // Low power: link edges ignored, clock enable rise wakes at once
            ddr_pwr_pkg::ST_PWRDN, ddr_pwr_pkg::ST_SREF: begin
                if (cke_s) begin
                    r_d.pst = ddr_pwr_pkg::ST_NORMAL;
                    r_d.cke_prev = 1'b1;
                    if (cmd != ddr_pwr_pkg::C_DESELECT_CMD && cmd != ddr_pwr_pkg::C_NOP) begin
                        bad = 1'b1;
                    end
                end
            end
            default: begin
                r_d.pst = ddr_pwr_pkg::ST_NORMAL;
            end
        endcase

        // Power state entries
        if (sref_go) begin
            r_d.pst = ddr_pwr_pkg::ST_SREF;
        end
        if (pd_go) begin
            r_d.pst = ddr_pwr_pkg::ST_PWRDN;
        end

        // Mode register writes capture the address pins
        if (base_wr || ext_wr) begin
            r_d.pst = ddr_pwr_pkg::ST_MRD;
            r_d.mrd_cnt = 2'(`MRD_TCK - 1);
        end
        if (base_wr) begin
            r_d.mode = a_s;
            r_d.mode_ok = 1'b1;
        end
        if (ext_wr) begin
            r_d.ext = a_s & `EM_MASK;
            r_d.ext_ok = 1'b1;
        end

        // Burst beats, one per aclk cycle; a new access cuts the old one
        r_d.col_vld = 1'b0;
        if (r_q.left != 5'h00) begin
            r_d.col = col_w;
            r_d.col_vld = 1'b1;
            r_d.beat = r_q.beat + 4'h1;
            r_d.left = r_q.left - 5'h01;
        end
        if (rw_go) begin
            r_d.start = a_s[3:0];
            r_d.beat = 4'h0;
            r_d.left = bl_len;
        end

        // Self refresh walks only the chosen rows
        if (r_q.pst == ddr_pwr_pkg::ST_SREF) begin
            if (r_q.ref_cnt >= interval) begin
                r_d.ref_cnt = '0;
                r_d.ref_stb = 1'b1;
                r_d.row = (r_q.row + AW'(1)) & partial_refresh_range_mask;
            end else begin
                r_d.ref_cnt = r_q.ref_cnt + CW'(1);
            end
        end else begin
            r_d.ref_cnt = '0;
        end

        // Register writes: address and data are taken together
        wr_go = awvalid & wvalid & ~r_q.bvalid;
        if (wr_go) begin
            r_d.bvalid = 1'b1;
            r_d.bresp = known(awaddr) ? `RESP_OKAY : `RESP_SLVERR;
            if (awaddr == `OFS_CTRL && wstrb[0]) begin
                r_d.dec_en = wdata[`CTRL_DEC_BIT];
                clr = wdata[`CTRL_CLR_BIT];
            end
        end else if (r_q.bvalid && bready) begin
            r_d.bvalid = 1'b0;
        end

        // Sticky flag: a new illegal command beats the clear
        if (clr) begin
            r_d.illegal = 1'b0;
        end
        if (bad) begin
            r_d.illegal = 1'b1;
        end

        // Register reads answer one cycle later
        rd_go = arvalid & ~r_q.rvalid;
        if (rd_go) begin
            r_d.rvalid = 1'b1;
            r_d.rresp = known(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (araddr)
                `OFS_CTRL: r_d.rdata = {31'h0, r_q.dec_en};
                `OFS_STATUS: r_d.rdata = {21'h0, r_q.illegal, r_q.ext_ok,
                    r_q.mode_ok, r_q.bank_act, r_q.pst};
                `OFS_MODE: r_d.rdata = {(32-AW)'(0), r_q.mode};
                `OFS_EXT: r_d.rdata = {(32-AW)'(0), r_q.ext};
                `OFS_REFRESH: r_d.rdata = {(32-AW)'(0), r_q.row};
                default: r_d.rdata = 32'h0;
            endcase
        end else if (r_q.rvalid && rready) begin
            r_d.rvalid = 1'b0;
        end
    end

    // One register for all state; frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_q <= '0;
            r_q.pst <= ddr_pwr_pkg::ST_NORMAL;
            r_q.dec_en <= `CTRL_DEC_RESET;
            r_q.mode <= `MODE_RESET;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    // Handshakes are combinational, payloads registered
    assign awready = wr_go & ce;
    assign wready = wr_go & ce;
    assign arready = ~r_q.rvalid & ce;
    assign bvalid = r_q.bvalid;
    assign bresp = r_q.bresp;
    assign rvalid = r_q.rvalid;
    assign rresp = r_q.rresp;
    assign rdata = r_q.rdata;
    assign burst_col = r_q.col;
    assign burst_valid = r_q.col_vld;
    assign refresh_row = r_q.row;
    assign refresh_stb = r_q.ref_stb;
    assign drive_strength = r_q.ext[`EM_DS_MSB:`EM_DS_LSB];

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic norm_edge;
    assign norm_edge = ce && r_q.pst == ddr_pwr_pkg::ST_NORMAL && edge_w && r_q.dec_en;

    AST_ACT_OTHER_BANK: assert property (
        norm_edge && r_q.cke_prev && cke_s && cmd == ddr_pwr_pkg::C_ACT &&
        !r_q.bank_act[ba_s] |=> r_q.bank_act[$past(ba_s)] && r_q.illegal == $past(r_q.illegal))
        else $error("activate of idle bank not opened");

    AST_PRE_CLOSES: assert property (
        norm_edge && r_q.cke_prev && cke_s && cmd == ddr_pwr_pkg::C_PRE && !a_s[10]
        |=> !r_q.bank_act[$past(ba_s)])
        else $error("precharge left bank open");

    AST_REF_BUSY: assert property (
        norm_edge && r_q.cke_prev && cke_s && cmd == ddr_pwr_pkg::C_REF && !idle_all
        |=> r_q.illegal)
        else $error("refresh with open bank not flagged");

    AST_WAKE: assert property (
        ce && (r_q.pst == ddr_pwr_pkg::ST_PWRDN || r_q.pst == ddr_pwr_pkg::ST_SREF) && cke_s
        |=> r_q.pst == ddr_pwr_pkg::ST_NORMAL && r_q.cke_prev)
        else $error("clock enable rise did not wake");

    AST_PD_ENTRY: assert property (
        norm_edge && r_q.cke_prev && !cke_s && idle_all &&
        (cmd == ddr_pwr_pkg::C_NOP || cmd == ddr_pwr_pkg::C_DESELECT_CMD)
        |=> r_q.pst == ddr_pwr_pkg::ST_PWRDN)
        else $error("power down not entered");

    AST_SREF_ENTRY: assert property (
        norm_edge && r_q.cke_prev && !cke_s && idle_all && cmd == ddr_pwr_pkg::C_REF
        |=> r_q.pst == ddr_pwr_pkg::ST_SREF)
        else $error("self refresh not entered");

    AST_BASE_CAPTURE: assert property (
        ce && base_wr |=> r_q.mode == $past(a_s) && r_q.mode_ok)
        else $error("base mode not captured");

    AST_EXT_FIELDS: assert property (
        ce && ext_wr |=> r_q.ext == ($past(a_s) & `EM_MASK) && r_q.ext_ok)
        else $error("extended mode not captured");

    AST_MRD_BUSY: assert property (
        ce && (base_wr || ext_wr) |=> r_q.pst == ddr_pwr_pkg::ST_MRD)
        else $error("mode write not held busy");

    AST_ROW_RANGE: assert property (
        r_q.ref_stb |-> (r_q.row & ~partial_refresh_range_mask) == '0)
        else $error("refresh row outside chosen portion");

    AST_SREF_HOLD: assert property (
        ce && r_q.pst == ddr_pwr_pkg::ST_SREF && !cke_s
        |=> r_q.pst == ddr_pwr_pkg::ST_SREF && $stable(r_q.bank_act) && $stable(r_q.mode))
        else $error("state changed during self refresh");

    COV_SREF: cover property (ce && sref_go);
    COV_PD: cover property (ce && pd_go);
    COV_EXT: cover property (ce && ext_wr);
    COV_BURST: cover property (ce && rw_go ##1 r_q.col_vld [*2]);

endmodule : ddr_pwr_ctrl

// >>> dv/mem_ctl_model.sv
// Purpose: memory controller model for the link side
// Assumes: link clock of 200 ns, still between commands
// Notes: pins change while the link clock is low
`timescale 1ns/1ps
module mem_ctl_model (
    output logic mem_clk,
    output logic mem_cke,
    output logic [3:0] cmd_n,
    output logic [1:0] mem_ba,
    output logic [12:0] mem_addr
);
    // Clock enable high from power up, before any link edge
    initial begin
        mem_clk = 1'b0;
        mem_cke = 1'b1;
        cmd_n = 4'hf;
        mem_ba = 2'h0;
        mem_addr = 13'h0000;
    end
    // One link cycle; the address is not held after the edge
    task automatic send(input logic k, input logic [3:0] c, input logic [1:0] b,
        input logic [12:0] a);
        mem_cke <= k;
        cmd_n <= c;
        mem_ba <= b;
        mem_addr <= a;
        #100 mem_clk <= 1'b1;
        #100 mem_clk <= 1'b0;
        mem_addr <= ~a;
    endtask : send
endmodule : mem_ctl_model

// >>> dv/ddr_pwr_ctrl_tb.sv
// Purpose: bench of power states, mode writes and register bus
// Assumes: link commands come from mem_ctl_model
// Notes: state is judged through the status register
`timescale 1ns/1ps
`include "ddr_pwr_regs.svh"
module ddr_pwr_ctrl_tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd, rdata;
    logic awready, wready, bvalid, arready, rvalid, bv, mclk, cke;
    logic [1:0] bresp, rresp, ba, ds;
    logic [3:0] cmd_n, col;
    logic [12:0] addr;
    logic [3:0] beats[$];
    logic [12:0] rrow;
    logic rs;
    int n_ref = 0;
    int n_fail = 0, tests_run = 0;
    always #12.5 aclk = ~aclk;
    // Collect burst beats as they appear
    always @(posedge aclk) if (bv === 1'b1) beats.push_back(col);
    // Count internal refresh pulses of self refresh
    always @(posedge aclk) if (rs === 1'b1) n_ref++;
    mem_ctl_model i_mem_ctl_model (.mem_clk(mclk), .mem_cke(cke), .cmd_n(cmd_n),
        .mem_ba(ba), .mem_addr(addr));
    ddr_pwr_ctrl #(.REFI_CYC(8)) i_ddr_pwr_ctrl (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .mem_clk(mclk), .mem_cke(cke), .mem_cs_n(cmd_n[3]),
        .mem_ras_n(cmd_n[2]), .mem_cas_n(cmd_n[1]), .mem_we_n(cmd_n[0]), .mem_ba(ba),
        .mem_addr(addr), .temp_hot(1'b0), .burst_col(col), .burst_valid(bv),
        .refresh_row(rrow), .refresh_stb(rs), .drive_strength(ds));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s %h/%h", $time, m, got, exp);
        end
        if (m == "to") wrap_up();
    endtask : chk
    // Bus write: address and data offered together, bready held until bvalid
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50 && bvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) begin
                awvalid <= 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        if (n == 50) chk(0, 1, "to");
        chk(32'(bresp), `RESP_OKAY, "bresp");
        @(posedge aclk);
    endtask : axw
    // Bus read with expected data and response
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 0);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50 && rvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (n == 50) chk(0, 1, "to");
        chk(32'(rresp), 32'(r), "rresp");
        chk(rdata, e, "rdata");
        @(posedge aclk);
    endtask : rc
    // One link command, then time for the synchroniser
    task automatic lk(input logic k, input logic [3:0] c, input logic [1:0] b = 0,
        input logic [12:0] a = 0);
        i_mem_ctl_model.send(k, c, b, a);
        repeat (6) @(posedge aclk);
    endtask : lk
    // Scenario: register bus right after reset
    task automatic t_bus();
        rc(`OFS_STATUS, 32'h1);
        rc(8'h40, 32'h0, `RESP_SLVERR);
        axw(`OFS_MODE, 32'h7f);
        rc(`OFS_MODE, 32'h0);
        $display("bus test done");
    endtask : t_bus
    // Scenario: power-up sequence and both mode writes
    task automatic t_init();
        repeat (8000) @(posedge aclk);
        lk(1, 4'h2, 0, 13'h0400);
        lk(1, 4'h7);
        repeat (2) lk(1, 4'h1);
        lk(1, 4'h0, 0, 13'h0032);
        lk(1, 4'h7);
        lk(1, 4'h0, 2'h2, 13'h0261);
        lk(1, 4'h7);
        rc(`OFS_MODE, 32'h32);
        rc(`OFS_EXT, 32'h261);
        rc(`OFS_STATUS, 32'h301);
        chk(32'(ds), 32'h3, "ds");
        $display("init test done");
    endtask : t_init
    // Scenario: sequential and interleaved bursts
    task automatic t_burst();
        for (int o = 0; o < 2; o++) begin
            lk(1, 4'h0, 0, 13'h0032 | 13'(o * 8));
            lk(1, 4'h7);
            lk(1, 4'h3);
            beats.delete();
            lk(1, 4'h5, 0, 13'h0005);
            repeat (2) lk(1, 4'h2);
            chk(beats.size(), 4, "len");
            for (int i = 0; i < 4; i++) chk(beats[i], o ? 5 ^ i : 4 + (1 + i) % 4, "col");
            rc(`OFS_STATUS, 32'h301);
        end
        $display("burst test done");
    endtask : t_burst
    // Scenario: power down, self refresh and wake-up
    task automatic t_pwr();
        lk(1, 4'h7);
        lk(0, 4'h7);
        rc(`OFS_STATUS, 32'h302);
        lk(1, 4'h7);
        rc(`OFS_STATUS, 32'h301);
        lk(0, 4'h1);
        rc(`OFS_STATUS, 32'h304);
        lk(0, 4'h3);
        repeat (2) lk(1, 4'h7);
        rc(`OFS_STATUS, 32'h301);
        chk(32'(rrow), 32'(n_ref) & 32'hfff, "row");
        chk(32'(n_ref inside {1, 2}), 1, "rate");
        $display("power test done");
    endtask : t_pwr
    // Scenario: illegal commands and clearing the flag
    task automatic t_ill();
        lk(1, 4'h3, 2'h1);
        lk(1, 4'h3);
        rc(`OFS_STATUS, 32'h331);
        lk(1, 4'h1);
        rc(`OFS_STATUS, 32'h731);
        lk(1, 4'h2, 0, 13'h0400);
        axw(`OFS_CTRL, 32'h3);
        rc(`OFS_STATUS, 32'h301);
        $display("illegal test done");
    endtask : t_ill
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_bus();
        t_init();
        t_burst();
        t_pwr();
        t_ill();
        wrap_up();
    end
endmodule : ddr_pwr_ctrl_tb
